// file: hw/pbd_defs.vh
/*
  Constants of the power budget data register block: byte offsets, field
  positions, reset values and array sizes.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef PBD_DEFS_VH
`define PBD_DEFS_VH

`define PBD_ADDR_W 12
`define PBD_DATA_W 32

`define PBD_OFF_SELECT 12'h284
`define PBD_OFF_WINDOW 12'h288
`define PBD_OFF_CAPFLAGS 12'h28C
`define PBD_OFF_VALUE_BASE 12'h300

`define PBD_ENTRIES 8
`define PBD_ENTRY_IDX_W 3
`define PBD_MAX_SELECT 8'h07

`define PBD_SEL_MSB 7
`define PBD_SEL_LSB 0
`define PBD_SEL_W 8
`define PBD_SA_BIT 0

`define PBD_SELECT_RST 8'h00
`define PBD_SA_RST 1'h0
`define PBD_RDATA_RST 32'h00000000

`endif

// file: hw/pbd_value_entry.v
/*
  One power budget data value register, 32 bits, with a write gate.
  Assumes a write strobe already decoded to this entry and an unlock level
  from the system control register outside this block.
*/
`timescale 1ns/100ps
`include "pbd_defs.vh"

module pbd_value_entry #(
  parameter WIDTH = `PBD_DATA_W
)
(
  input wire clk,
  input wire wr_hit,
  input wire unlock,
  input wire [WIDTH-1:0] wdata,
  output wire [WIDTH-1:0] value
);

  reg [WIDTH-1:0] value_q;
  wire [WIDTH-1:0] value_d;

  // The content is sticky: it carries no reset so that it survives every
  // reset of the device, and reads undefined until software or an
  // initialisation agent has written it.
  assign value_d = (wr_hit && unlock) ? wdata : value_q;

  always @(posedge clk)
  begin
    value_q <= value_d;
  end

  assign value = value_q;

endmodule // pbd_value_entry

// file: hw/pbd_window_mux.v
/*
  Data window selector: picks one stored value by the select field and
  returns zero for any selection beyond the last entry.
  Assumes the entries arrive packed, entry 0 in the low word.
*/
`timescale 1ns/100ps
`include "pbd_defs.vh"

module pbd_window_mux #(
  parameter WIDTH = `PBD_DATA_W,
  parameter ENTRIES = `PBD_ENTRIES
)
(
  input wire [`PBD_SEL_W-1:0] select,
  input wire [ENTRIES*WIDTH-1:0] entries,
  output reg [WIDTH-1:0] window
);

  always @*
  begin
    window = {WIDTH{1'b0}};
    if (select <= `PBD_MAX_SELECT)
    begin
      window = entries[select[`PBD_ENTRY_IDX_W-1:0]*WIDTH +: WIDTH];
    end
  end

endmodule // pbd_window_mux

// file: hw/pbd_budget_regs.v
/*
  Power budget data register block: data select register, read-only data
  window, capability flags register and an array of eight sticky data
  value registers, all reached over a plain register port.
  Assumes the value write unlock level comes from the system control
  register elsewhere in the device, and that the master never raises both
  strobes in one cycle.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "pbd_defs.vh"

module pbd_budget_regs #(
  parameter ENTRIES = `PBD_ENTRIES
)
(
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire [`PBD_ADDR_W-1:0] REG_ADDR,
  input wire [`PBD_DATA_W-1:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output wire [`PBD_DATA_W-1:0] REG_RDATA,
  input wire VALUE_WRITE_UNLOCK,
  output wire SYSTEM_ALLOCATED
);

  reg [`PBD_SEL_W-1:0] value_select_field_q;
  reg [`PBD_SEL_W-1:0] value_select_field_d;
  reg system_allocated_flag_q;
  reg system_allocated_flag_d;
  reg [`PBD_DATA_W-1:0] rdata_q;
  reg [`PBD_DATA_W-1:0] rdata_d;

  wire hit_select;
  wire hit_window;
  wire hit_capflags;
  wire hit_values;
  wire [`PBD_ENTRY_IDX_W-1:0] entry_idx;
  wire [ENTRIES*`PBD_DATA_W-1:0] entries_flat;
  wire [`PBD_DATA_W-1:0] window_value;
  wire [`PBD_DATA_W-1:0] entry_rd_value;
  wire [`PBD_ADDR_W-1:0] value_end;
  wire [31:0] value_end_full;

  // The end offset is worked out at full integer width and then cut to the address width.
  assign value_end_full = `PBD_OFF_VALUE_BASE + ENTRIES * 4;
  assign value_end = value_end_full[`PBD_ADDR_W-1:0];

  // Only aligned word addresses decode; the low two address bits must be zero.
  assign hit_select = (REG_ADDR == `PBD_OFF_SELECT);
  assign hit_window = (REG_ADDR == `PBD_OFF_WINDOW);
  assign hit_capflags = (REG_ADDR == `PBD_OFF_CAPFLAGS);
  assign hit_values = (REG_ADDR >= `PBD_OFF_VALUE_BASE) && (REG_ADDR < value_end) &&
    (REG_ADDR[1:0] == 2'h0);
  assign entry_idx = REG_ADDR[`PBD_ENTRY_IDX_W+1:2];

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi = gi + 1)
    begin : g_entry
      pbd_value_entry #(
        .WIDTH(`PBD_DATA_W)
      ) u_entry (
        .clk(SYS_CLK),
        .wr_hit(REG_WR && hit_values && (entry_idx == gi)),
        .unlock(VALUE_WRITE_UNLOCK),
        .wdata(REG_WDATA),
        .value(entries_flat[gi*`PBD_DATA_W +: `PBD_DATA_W])
      );
    end
  endgenerate

  pbd_window_mux #(
    .WIDTH(`PBD_DATA_W),
    .ENTRIES(ENTRIES)
  ) u_window (
    .select(value_select_field_q),
    .entries(entries_flat),
    .window(window_value)
  );

  assign entry_rd_value = entries_flat[entry_idx*`PBD_DATA_W +: `PBD_DATA_W];

  always @*
  begin
    value_select_field_d = value_select_field_q;
    system_allocated_flag_d = system_allocated_flag_q;
    if (REG_WR && hit_select)
    begin
      // Bits 31:8 are reserved and simply not stored.
      value_select_field_d = REG_WDATA[`PBD_SEL_MSB:`PBD_SEL_LSB];
    end
    // The flag is lockable like the value array, so it shares the unlock gate.
    if (REG_WR && hit_capflags && VALUE_WRITE_UNLOCK)
    begin
      system_allocated_flag_d = REG_WDATA[`PBD_SA_BIT];
    end
  end

  // Read data stand only in the cycle after the read strobe and are zero
  // otherwise, so a stale word can never be mistaken for a fresh answer.
  always @*
  begin
    rdata_d = `PBD_RDATA_RST;
    if (REG_RD)
    begin
      if (hit_select)
      begin
        rdata_d[`PBD_SEL_MSB:`PBD_SEL_LSB] = value_select_field_q;
      end
      else if (hit_window)
      begin
        rdata_d = window_value;
      end
      else if (hit_capflags)
      begin
        rdata_d[`PBD_SA_BIT] = system_allocated_flag_q;
      end
      else if (hit_values)
      begin
        rdata_d = entry_rd_value;
      end
    end
  end

  always @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      value_select_field_q <= `PBD_SELECT_RST;
      system_allocated_flag_q <= `PBD_SA_RST;
      rdata_q <= `PBD_RDATA_RST;
    end
    else
    begin
      value_select_field_q <= value_select_field_d;
      system_allocated_flag_q <= system_allocated_flag_d;
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign SYSTEM_ALLOCATED = system_allocated_flag_q;

endmodule // pbd_budget_regs

// file: testbench/pbd_assertions.sv
/*
  Checker for the power budget register block, bound to its top module.
  Assumes one clock, asynchronous active-high reset, one strobe at a time.
*/
`timescale 1ns/100ps
module pbd_checker #(
  parameter ENTRIES = 8
)
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [11:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic VALUE_WRITE_UNLOCK,
  input wire logic SYSTEM_ALLOCATED
);
  logic [7:0] sel_q;
  logic sa_wr;
  logic mapped;
  assign sa_wr = REG_WR && VALUE_WRITE_UNLOCK && REG_ADDR == 12'h28C;
  assign mapped = REG_ADDR inside {12'h284, 12'h288, 12'h28C} ||
    (REG_ADDR[11:5] == 7'h18 && REG_ADDR[1:0] == 2'h0);
  // Shadow of the select field, so window reads can be judged.
  always @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
      sel_q <= 8'h00;
    else if (REG_WR && REG_ADDR == 12'h284)
      sel_q <= REG_WDATA[7:0];
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_select_echo: assert property (REG_RD && REG_ADDR == 12'h284 |=>
    REG_RDATA == {24'h0, sel_q}) else $error("select readback wrong");
  a_window_zero: assert property (REG_RD && REG_ADDR == 12'h288 &&
    sel_q > ENTRIES - 1 |=> REG_RDATA == 32'h0) else $error("window not zero");
  a_cap_read: assert property (REG_RD && REG_ADDR == 12'h28C |=>
    REG_RDATA == {31'h0, SYSTEM_ALLOCATED}) else $error("flag readback wrong");
  a_flag_hold: assert property (!sa_wr |=> $stable(SYSTEM_ALLOCATED))
    else $error("flag changed without unlocked write");
  a_flag_write: assert property (sa_wr |=> SYSTEM_ALLOCATED == $past(REG_WDATA[0]))
    else $error("flag write lost");
  a_unmapped_zero: assert property (REG_RD && !mapped |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
endmodule // pbd_checker
bind pbd_budget_regs pbd_checker #(.ENTRIES(ENTRIES)) i_pbd_checker (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .VALUE_WRITE_UNLOCK(VALUE_WRITE_UNLOCK), .SYSTEM_ALLOCATED(SYSTEM_ALLOCATED));

// file: testbench/tb.sv
/*
  Self-checking bench for the power budget register block.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
module tb;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [11:0] REG_ADDR = 12'h000;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic VALUE_WRITE_UNLOCK = 1'b0;
  wire [31:0] REG_RDATA;
  wire SYSTEM_ALLOCATED;
  int err_total = 0;
  int num_checks = 0;
  // Each row: address, write data, unlock level, expected readback.
  logic [76:0] rows [13] = '{
    {12'h300, 32'hAAAA0000, 1'h1, 32'hAAAA0000},
    {12'h304, 32'h12345678, 1'h1, 32'h12345678},
    {12'h300, 32'hFFFFFFFF, 1'h0, 32'hAAAA0000},
    {12'h284, 32'hFFFFFF01, 1'h1, 32'h00000001},
    {12'h288, 32'hDEADBEEF, 1'h1, 32'h12345678},
    {12'h31C, 32'h0000BEEF, 1'h1, 32'h0000BEEF},
    {12'h284, 32'h00000007, 1'h1, 32'h00000007},
    {12'h288, 32'h00000000, 1'h1, 32'h0000BEEF},
    {12'h284, 32'h00000008, 1'h1, 32'h00000008},
    {12'h288, 32'h00000000, 1'h1, 32'h00000000},
    {12'h28C, 32'hFFFFFFFF, 1'h1, 32'h00000001},
    {12'h28C, 32'h00000000, 1'h0, 32'h00000001},
    {12'h302, 32'h00000055, 1'h1, 32'h00000000}};
  pbd_budget_regs i_pbd_budget_regs (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .VALUE_WRITE_UNLOCK(VALUE_WRITE_UNLOCK),
    .SYSTEM_ALLOCATED(SYSTEM_ALLOCATED));
  always #5 SYS_CLK = ~SYS_CLK;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic u);
    REG_ADDR <= a;
    REG_WDATA <= d;
    VALUE_WRITE_UNLOCK <= u;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  // Data lands at the strobe edge; looking 1 ns later avoids the edge race.
  task rd(input logic [11:0] a, input logic [31:0] exp);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, exp);
    @(posedge SYS_CLK);
  endtask
  task test_done;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i][76:65], rows[i][64:33], rows[i][32]);
      rd(rows[i][76:65], rows[i][31:0]);
    end
    chk({31'h0, SYSTEM_ALLOCATED}, 32'h1);
    $display("table test ended");
    SYS_RST <= 1'b1;
    @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    chk({31'h0, SYSTEM_ALLOCATED}, 32'h0);
    rd(12'h284, 32'h0);
    rd(12'h28C, 32'h0);
    rd(12'h300, 32'hAAAA0000);
    rd(12'h288, 32'hAAAA0000);
    $display("reset test ended");
    test_done;
  end
  initial
  begin
    #3000;
    err_total++;
    test_done;
  end
endmodule // tb
